// ==== hdl/core_model_regs.svh ====
// offsets, field positions, reset values and timing counts of the core register model
`ifndef CORE_MODEL_REGS_SVH
`define CORE_MODEL_REGS_SVH

`define IDX_PTR_HIGH_OFS 8'hBE
`define IDX_PTR_LOW_OFS 8'hBF
`define COND_FLAGS_OFS 8'hEF
`define STACK_TOP_OFS 8'hEE

`define STACK_BASE 8'h30
`define SP_RESET 4'hF
`define PC_RESET 11'h000
`define PROG_SEL_BIT 11

`define FLG_READY 7
`define FLG_G 4
`define FLG_Z 3
`define FLG_C 2
`define FLG_H 1
`define FLG_N 0
`define FLG_WR_MASK 8'h1F

`define VEC_EDGE 11'h7F6
`define VEC_TMR0 11'h7F8
`define VEC_TMR1 11'h7FA
`define VEC_SOFT 11'h7FC

`define IRQ_ENTRY_CYCLES 5

`endif

// ==== hdl/core_model_pkg.sv ====
// types shared by the core register model
package core_model_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_LD_A, OP_ADD, OP_ADC, OP_SUBC, OP_AND, OP_OR, OP_XOR,
    OP_INC_A, OP_DEC_A, OP_CLR_A, OP_RLC, OP_RRC, OP_SC, OP_RC,
    OP_LOAD_CARRY_BIT, OP_INVERT_CARRY, OP_LD_X, OP_INC_X, OP_DEC_X,
    OP_IDX_RD, OP_IDX_WR, OP_JMP, OP_CALL_SUBROUTINE, OP_SUBROUTINE_RETURN,
    OP_INTERRUPT_RETURN, OP_SOFTWARE_INTERRUPT, OP_SET_G
  } op_t;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_PUSH_LO, SEQ_PUSH_HI, SEQ_VECTOR, SEQ_SETTLE,
    SEQ_PULL_HI, SEQ_PULL_LO, SEQ_PULL_END
  } seq_t;

  typedef enum logic [1:0] {IRQ_EDGE, IRQ_TMR0, IRQ_TMR1, IRQ_SOFT} irq_src_t;

  typedef struct packed {
    logic ready;
    logic [1:0] spare;
    logic g;
    logic z;
    logic c;
    logic h;
    logic n;
  } flags_t;

  typedef struct packed {
    logic [7:0] result;
    logic c;
    logic h;
    logic wr_a;
    logic upd_c;
    logic upd_h;
    logic upd_zn;
  } alu_res_t;

  typedef struct packed {
    logic take;
    irq_src_t src;
    logic [10:0] vector;
  } irq_sel_t;

endpackage

// ==== hdl/core_alu.sv ====
// accumulator arithmetic and carry manipulation with flag results
`timescale 1ns/1ps
`include "core_model_regs.svh"
module core_alu
  import core_model_pkg::*;
(
  input wire op_t op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] opnd_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic carry_in,
  output alu_res_t res_out
);

  // nine-bit sum plus carry out of bit 3
  function automatic logic [9:0] add_hc(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    add_hc = {lo[4], s};
  endfunction

  always_comb begin
    logic [9:0] sum;
    sum = 10'h000;
    res_out = '0;
    unique case (op_in)
      OP_LD_A: begin
        res_out.result = opnd_in;
        res_out.wr_a = 1'b1;
        res_out.upd_zn = 1'b1;
      end
      OP_ADD, OP_ADC, OP_SUBC, OP_INC_A, OP_DEC_A: begin
        unique case (op_in)
          OP_ADD: sum = add_hc(acc_in, opnd_in, 1'b0);
          OP_ADC: sum = add_hc(acc_in, opnd_in, carry_in);
          OP_SUBC: sum = add_hc(acc_in, ~opnd_in, carry_in);
          OP_INC_A: sum = add_hc(acc_in, 8'h01, 1'b0);
          default: sum = add_hc(acc_in, 8'hFF, 1'b0);
        endcase
        res_out.result = sum[7:0];
        res_out.c = sum[8];
        res_out.h = sum[9];
        res_out.wr_a = 1'b1;
        res_out.upd_zn = 1'b1;
        res_out.upd_c = (op_in == OP_ADC) || (op_in == OP_SUBC);
        res_out.upd_h = res_out.upd_c;
      end
      OP_AND, OP_OR, OP_XOR, OP_CLR_A: begin
        unique case (op_in)
          OP_AND: res_out.result = acc_in & opnd_in;
          OP_OR: res_out.result = acc_in | opnd_in;
          OP_XOR: res_out.result = acc_in ^ opnd_in;
          default: res_out.result = 8'h00;
        endcase
        res_out.wr_a = 1'b1;
        res_out.upd_zn = 1'b1;
      end
      OP_RLC, OP_RRC: begin
        res_out.result = (op_in == OP_RLC) ? {acc_in[6:0], carry_in} : {carry_in, acc_in[7:1]};
        res_out.c = (op_in == OP_RLC) ? acc_in[7] : acc_in[0];
        res_out.wr_a = 1'b1;
        res_out.upd_c = 1'b1;
        res_out.upd_zn = 1'b1;
      end
      OP_SC, OP_RC, OP_LOAD_CARRY_BIT, OP_INVERT_CARRY: begin
        unique case (op_in)
          OP_SC: res_out.c = 1'b1;
          OP_RC: res_out.c = 1'b0;
          OP_LOAD_CARRY_BIT: res_out.c = opnd_in[bit_sel_in];
          default: res_out.c = ~carry_in;
        endcase
        res_out.upd_c = 1'b1;
      end
      default: res_out = '0;
    endcase
  end

endmodule

// ==== hdl/core_irq_arbiter.sv ====
// fixed-priority interrupt selection, edge and timer requests gated by the global mask, software request taken regardless of it
`timescale 1ns/1ps
`include "core_model_regs.svh"
module core_irq_arbiter
  import core_model_pkg::*;
(
  input wire logic edge_pend_in,
  input wire logic tmr0_pend_in,
  input wire logic tmr1_pend_in,
  input wire logic soft_pend_in,
  input wire logic g_in,
  output irq_sel_t sel_out
);

  always_comb begin
    sel_out.take = 1'b1;
    sel_out.src = IRQ_SOFT;
    sel_out.vector = `VEC_SOFT;
    if (g_in && edge_pend_in) begin
      sel_out.src = IRQ_EDGE;
      sel_out.vector = `VEC_EDGE;
    end else if (g_in && tmr0_pend_in) begin
      sel_out.src = IRQ_TMR0;
      sel_out.vector = `VEC_TMR0;
    end else if (g_in && tmr1_pend_in) begin
      sel_out.src = IRQ_TMR1;
      sel_out.vector = `VEC_TMR1;
    end else if (!soft_pend_in) begin
      sel_out.take = 1'b0;
    end
  end

endmodule

// ==== hdl/core_prog_model.sv ====
// programming-model registers, stack sequencing and interrupt entry of the core
`timescale 1ns/1ps
`include "core_model_regs.svh"
module core_prog_model
  import core_model_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic CMD_VALID_IN,
  input wire op_t CMD_OP_IN,
  input wire logic [7:0] CMD_DATA_IN,
  input wire logic [11:0] CMD_ADDR_IN,
  input wire logic [1:0] CMD_LEN_IN,
  output logic CMD_READY_OUT,
  input wire logic MAP_WR_IN,
  input wire logic MAP_RD_IN,
  input wire logic [7:0] MAP_ADDR_IN,
  input wire logic [7:0] MAP_WDATA_IN,
  output logic [7:0] MAP_RDATA_OUT,
  input wire logic [7:0] MEM_RDATA_IN,
  output logic [7:0] MEM_ADDR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  output logic MEM_WE_OUT,
  output logic MEM_RE_OUT,
  output logic [11:0] EA_OUT,
  output logic EA_RE_OUT,
  output logic EA_WE_OUT,
  output logic [11:0] FETCH_ADDR_OUT,
  output logic [7:0] ACC_OUT,
  output logic [7:0] FLAGS_OUT,
  output logic [3:0] SP_OUT,
  input wire logic EE_READY_IN,
  input wire logic IRQ_EDGE_IN,
  input wire logic IRQ_TMR0_IN,
  input wire logic IRQ_TMR1_IN,
  output logic IRQ_TAKEN_OUT,
  output irq_src_t IRQ_SRC_OUT
);

  typedef struct packed {
    seq_t seq;
    logic [7:0] acc;
    logic [11:0] x;
    logic [10:0] pc;
    logic [3:0] sp;
    flags_t f;
    logic sw_pend;
    logic in_irq;
    logic pull_sets_g;
    logic [10:0] return_pc;
    logic [10:0] vec;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [7:0] map_rdata;
    logic [11:0] ea;
    logic ea_re;
    logic ea_we;
    logic irq_taken;
    irq_src_t irq_src;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;
  alu_res_t alu_res;
  irq_sel_t irq_sel;
  logic accept;
  logic take_irq;

  // stack slot address for a pointer value
  function automatic logic [7:0] stack_addr(input logic [3:0] sp);
    stack_addr = `STACK_BASE | {4'h0, sp};
  endfunction

  // indexed address with space selection
  function automatic logic [11:0] index_addr(input logic [11:0] x, input logic [7:0] ofs);
    logic [10:0] sum;
    sum = x[10:0] + {3'b000, ofs};
    if (x[`PROG_SEL_BIT]) begin
      index_addr = {1'b1, sum};
    end else begin
      index_addr = {4'h0, sum[7:0]};
    end
  endfunction

  core_alu u_alu (
    .op_in(CMD_OP_IN),
    .acc_in(st_r.acc),
    .opnd_in(CMD_DATA_IN),
    .bit_sel_in(CMD_ADDR_IN[2:0]),
    .carry_in(st_r.f.c),
    .res_out(alu_res)
  );

  core_irq_arbiter u_irq (
    .edge_pend_in(IRQ_EDGE_IN),
    .tmr0_pend_in(IRQ_TMR0_IN),
    .tmr1_pend_in(IRQ_TMR1_IN),
    .soft_pend_in(st_r.sw_pend),
    .g_in(st_r.f.g),
    .sel_out(irq_sel)
  );

  // interrupts are taken only between instructions
  assign take_irq = (st_r.seq == SEQ_IDLE) && irq_sel.take;
  assign CMD_READY_OUT = (st_r.seq == SEQ_IDLE) && !take_irq;
  assign accept = CMD_VALID_IN && CMD_READY_OUT;

  always_comb begin
    logic [10:0] next_pc;
    next_pc = st_r.pc + {9'h000, CMD_LEN_IN};
    st_nxt = st_r;
    st_nxt.mem_we = 1'b0;
    st_nxt.mem_re = 1'b0;
    st_nxt.ea_re = 1'b0;
    st_nxt.ea_we = 1'b0;
    st_nxt.irq_taken = 1'b0;
    st_nxt.f.ready = EE_READY_IN;
    st_nxt.f.spare = 2'b00;
    unique case (st_r.seq)
      SEQ_IDLE: begin
        if (take_irq) begin
          st_nxt.irq_taken = 1'b1;
          st_nxt.irq_src = irq_sel.src;
          st_nxt.vec = irq_sel.vector;
          st_nxt.return_pc = st_r.pc;
          st_nxt.in_irq = 1'b1;
          if (irq_sel.src == IRQ_SOFT) begin
            st_nxt.sw_pend = 1'b0;
          end
          st_nxt.mem_we = 1'b1;
          st_nxt.mem_addr = stack_addr(st_r.sp);
          st_nxt.mem_wdata = st_r.pc[7:0];
          st_nxt.seq = SEQ_PUSH_LO;
        end else if (accept) begin
          st_nxt.pc = next_pc;
          if (alu_res.wr_a) begin
            st_nxt.acc = alu_res.result;
          end
          if (alu_res.upd_c) begin
            st_nxt.f.c = alu_res.c;
          end
          if (alu_res.upd_h) begin
            st_nxt.f.h = alu_res.h;
          end
          if (alu_res.upd_zn) begin
            st_nxt.f.z = (alu_res.result == 8'h00);
            st_nxt.f.n = alu_res.result[7];
          end
          unique case (CMD_OP_IN)
            OP_LD_X: st_nxt.x = CMD_ADDR_IN;
            OP_INC_X: st_nxt.x[10:0] = st_r.x[10:0] + 11'h001;
            OP_DEC_X: st_nxt.x[10:0] = st_r.x[10:0] - 11'h001;
            OP_IDX_RD: begin
              st_nxt.ea = index_addr(st_r.x, CMD_DATA_IN);
              st_nxt.ea_re = 1'b1;
            end
            OP_IDX_WR: begin
              st_nxt.ea = index_addr(st_r.x, CMD_DATA_IN);
              st_nxt.ea_we = !st_r.x[`PROG_SEL_BIT];
            end
            OP_JMP: st_nxt.pc = CMD_ADDR_IN[10:0];
            OP_CALL_SUBROUTINE: begin
              st_nxt.return_pc = next_pc;
              st_nxt.vec = CMD_ADDR_IN[10:0];
              st_nxt.in_irq = 1'b0;
              st_nxt.mem_we = 1'b1;
              st_nxt.mem_addr = stack_addr(st_r.sp);
              st_nxt.mem_wdata = next_pc[7:0];
              st_nxt.seq = SEQ_PUSH_LO;
            end
            OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
              st_nxt.pull_sets_g = (CMD_OP_IN == OP_INTERRUPT_RETURN);
              st_nxt.mem_re = 1'b1;
              st_nxt.mem_addr = stack_addr(st_r.sp + 4'h1);
              st_nxt.seq = SEQ_PULL_HI;
            end
            OP_SOFTWARE_INTERRUPT: st_nxt.sw_pend = 1'b1;
            OP_SET_G: st_nxt.f.g = 1'b1;
            default: st_nxt.sw_pend = st_r.sw_pend;
          endcase
        end
      end
      SEQ_PUSH_LO: begin
        st_nxt.mem_we = 1'b1;
        st_nxt.mem_addr = stack_addr(st_r.sp - 4'h1);
        st_nxt.mem_wdata = {5'b00000, st_r.return_pc[10:8]};
        st_nxt.seq = SEQ_PUSH_HI;
      end
      SEQ_PUSH_HI: begin
        st_nxt.sp = st_r.sp - 4'h2;
        if (st_r.in_irq) begin
          st_nxt.seq = SEQ_VECTOR;
        end else begin
          st_nxt.pc = st_r.vec;
          st_nxt.seq = SEQ_IDLE;
        end
      end
      SEQ_VECTOR: begin
        st_nxt.pc = st_r.vec;
        st_nxt.f.g = 1'b0;
        st_nxt.seq = SEQ_SETTLE;
      end
      SEQ_SETTLE: begin
        st_nxt.in_irq = 1'b0;
        st_nxt.seq = SEQ_IDLE;
      end
      SEQ_PULL_HI: begin
        st_nxt.mem_re = 1'b1;
        st_nxt.mem_addr = stack_addr(st_r.sp + 4'h2);
        st_nxt.seq = SEQ_PULL_LO;
      end
      SEQ_PULL_LO: begin
        st_nxt.return_pc[10:8] = MEM_RDATA_IN[2:0];
        st_nxt.seq = SEQ_PULL_END;
      end
      SEQ_PULL_END: begin
        st_nxt.pc = {st_r.return_pc[10:8], MEM_RDATA_IN};
        st_nxt.sp = st_r.sp + 4'h2;
        if (st_r.pull_sets_g) begin
          st_nxt.f.g = 1'b1;
        end
        st_nxt.seq = SEQ_IDLE;
      end
      default: st_nxt.seq = SEQ_IDLE;
    endcase
    // mapped byte access from the memory map
    if (MAP_RD_IN) begin
      unique case (MAP_ADDR_IN)
        `IDX_PTR_HIGH_OFS: st_nxt.map_rdata = {5'b00000, st_r.x[10:8]};
        `IDX_PTR_LOW_OFS: st_nxt.map_rdata = st_r.x[7:0];
        `COND_FLAGS_OFS: st_nxt.map_rdata = st_r.f;
        `STACK_TOP_OFS: st_nxt.map_rdata = {4'h0, st_r.sp};
        default: st_nxt.map_rdata = 8'h00;
      endcase
    end
    if (MAP_WR_IN) begin
      unique case (MAP_ADDR_IN)
        `IDX_PTR_HIGH_OFS: st_nxt.x[11:8] = MAP_WDATA_IN[3:0];
        `IDX_PTR_LOW_OFS: st_nxt.x[7:0] = MAP_WDATA_IN;
        `COND_FLAGS_OFS: begin
          st_nxt.f = (st_nxt.f & ~`FLG_WR_MASK) | (MAP_WDATA_IN & `FLG_WR_MASK);
        end
        `STACK_TOP_OFS: st_nxt.sp = MAP_WDATA_IN[3:0];
        default: st_nxt.map_rdata = st_nxt.map_rdata;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_r <= '0;
      st_r.seq <= SEQ_IDLE;
      st_r.pc <= `PC_RESET;
      st_r.sp <= `SP_RESET;
      st_r.f.g <= 1'b0;
      st_r.irq_src <= IRQ_EDGE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign FETCH_ADDR_OUT = {1'b1, st_r.pc};
  assign MAP_RDATA_OUT = st_r.map_rdata;
  assign MEM_ADDR_OUT = st_r.mem_addr;
  assign MEM_WDATA_OUT = st_r.mem_wdata;
  assign MEM_WE_OUT = st_r.mem_we;
  assign MEM_RE_OUT = st_r.mem_re;
  assign EA_OUT = st_r.ea;
  assign EA_RE_OUT = st_r.ea_re;
  assign EA_WE_OUT = st_r.ea_we;
  assign ACC_OUT = st_r.acc;
  assign FLAGS_OUT = st_r.f;
  assign SP_OUT = st_r.sp;
  assign IRQ_TAKEN_OUT = st_r.irq_taken;
  assign IRQ_SRC_OUT = st_r.irq_src;

endmodule

// ==== tb/core_prog_model_assertions.sv ====
// concurrent checks on the ports of the core register model
`timescale 1ns/1ps
`include "core_model_regs.svh"
module core_prog_model_assertions
  import core_model_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic CMD_VALID_IN,
  input wire op_t CMD_OP_IN,
  input wire logic CMD_READY_OUT,
  input wire logic [7:0] MEM_ADDR_OUT,
  input wire logic MEM_WE_OUT,
  input wire logic MEM_RE_OUT,
  input wire logic [11:0] EA_OUT,
  input wire logic EA_WE_OUT,
  input wire logic [11:0] FETCH_ADDR_OUT,
  input wire logic [7:0] FLAGS_OUT,
  input wire logic [3:0] SP_OUT,
  input wire logic EE_READY_IN,
  input wire logic IRQ_EDGE_IN,
  input wire logic IRQ_TMR0_IN,
  input wire logic IRQ_TAKEN_OUT,
  input wire irq_src_t IRQ_SRC_OUT
);
  logic acc;
  logic [3:0] sp_cap_r;
  logic [10:0] vec_r;
  assign acc = CMD_VALID_IN && CMD_READY_OUT;
  // stack pointer at accept, vector of the taken source
  always_ff @(posedge CLK_SYS_IN) begin
    if (acc) begin
      sp_cap_r <= SP_OUT;
    end
    if (IRQ_TAKEN_OUT) begin
      vec_r <= `VEC_EDGE + {8'h00, IRQ_SRC_OUT, 1'b0};
    end
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence push_s(logic [3:0] sp);
    (MEM_WE_OUT && MEM_ADDR_OUT == {4'h3, sp}) ##1
    (MEM_WE_OUT && MEM_ADDR_OUT == {4'h3, sp - 4'h1});
  endsequence
  sequence pull_s;
    (MEM_RE_OUT && MEM_ADDR_OUT == {4'h3, sp_cap_r + 4'h1}) ##1
    (MEM_RE_OUT && MEM_ADDR_OUT == {4'h3, sp_cap_r + 4'h2});
  endsequence
  chk_reset_values: assert property ($fell(SYS_RST_IN) |->
    SP_OUT == 4'hF && FETCH_ADDR_OUT == 12'h0800 && !FLAGS_OUT[`FLG_G])
    else $error("reset values wrong");
  chk_call_push: assert property (acc && CMD_OP_IN == OP_CALL_SUBROUTINE |->
    ##1 push_s(sp_cap_r) ##[1:2] SP_OUT == sp_cap_r - 4'h2)
    else $error("call push sequence wrong");
  chk_return_pull: assert property (acc && CMD_OP_IN == OP_SUBROUTINE_RETURN |->
    ##1 pull_s ##[1:3] SP_OUT == sp_cap_r + 4'h2)
    else $error("return pull sequence wrong");
  chk_irq_return_mask: assert property (acc && CMD_OP_IN == OP_INTERRUPT_RETURN |->
    ##1 pull_s ##[1:3] (FLAGS_OUT[`FLG_G] && SP_OUT == sp_cap_r + 4'h2))
    else $error("interrupt return wrong");
  chk_irq_entry: assert property (IRQ_TAKEN_OUT |-> push_s(SP_OUT) ##[1:3]
    (FETCH_ADDR_OUT == {1'b1, vec_r} && !FLAGS_OUT[`FLG_G]))
    else $error("interrupt entry wrong");
  chk_irq_masked: assert property (IRQ_TAKEN_OUT && IRQ_SRC_OUT != IRQ_SOFT |->
    $past(FLAGS_OUT[`FLG_G]))
    else $error("masked request taken");
  chk_irq_priority: assert property (IRQ_TAKEN_OUT && IRQ_SRC_OUT != IRQ_EDGE |->
    !$past(IRQ_EDGE_IN) || !$past(FLAGS_OUT[`FLG_G]))
    else $error("priority order wrong");
  chk_timer_order: assert property (IRQ_TAKEN_OUT && IRQ_SRC_OUT == IRQ_TMR1 |->
    !$past(IRQ_TMR0_IN))
    else $error("timer priority wrong");
  chk_ready_copy: assert property (!$past(SYS_RST_IN) |->
    FLAGS_OUT[`FLG_READY] == $past(EE_READY_IN))
    else $error("ready flag not copied");
  chk_code_write: assert property (EA_WE_OUT |-> !EA_OUT[11])
    else $error("write into program space");
endmodule

bind core_prog_model core_prog_model_assertions core_prog_model_assertions_i (
  .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_OP_IN(CMD_OP_IN), .CMD_READY_OUT(CMD_READY_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
  .MEM_WE_OUT(MEM_WE_OUT), .MEM_RE_OUT(MEM_RE_OUT), .EA_OUT(EA_OUT), .EA_WE_OUT(EA_WE_OUT),
  .FETCH_ADDR_OUT(FETCH_ADDR_OUT), .FLAGS_OUT(FLAGS_OUT), .SP_OUT(SP_OUT),
  .EE_READY_IN(EE_READY_IN), .IRQ_EDGE_IN(IRQ_EDGE_IN), .IRQ_TMR0_IN(IRQ_TMR0_IN),
  .IRQ_TAKEN_OUT(IRQ_TAKEN_OUT), .IRQ_SRC_OUT(IRQ_SRC_OUT));

// ==== tb/stack_ram_model.sv ====
// stack ram answering the core's push and pull strobes
`timescale 1ns/1ps
module stack_ram_model (
  input wire logic clk_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic we_in,
  input wire logic re_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [16];
  initial rdata_out = 8'h00;
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in[3:0]] <= wdata_in;
    end
    // data valid one cycle after the read strobe, scrambled otherwise
    if (re_in) begin
      rdata_out <= mem[addr_in[3:0]];
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the core register model
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench
  import core_model_pkg::*;
;
  logic CLK_SYS_IN = 1'b0, SYS_RST_IN = 1'b1, CMD_VALID_IN = 1'b0, CMD_READY_OUT;
  op_t CMD_OP_IN = OP_NONE;
  logic [7:0] CMD_DATA_IN = 8'h00, MAP_ADDR_IN = 8'h00, MAP_WDATA_IN = 8'h00;
  logic [11:0] CMD_ADDR_IN = 12'h000, EA_OUT, FETCH_ADDR_OUT, ea_seen;
  logic [1:0] CMD_LEN_IN = 2'h1;
  logic MAP_WR_IN = 1'b0, MAP_RD_IN = 1'b0, EE_READY_IN = 1'b1;
  logic IRQ_EDGE_IN = 1'b0, IRQ_TMR0_IN = 1'b0, IRQ_TMR1_IN = 1'b0;
  logic [7:0] MAP_RDATA_OUT, MEM_RDATA_IN, MEM_ADDR_OUT, MEM_WDATA_OUT, ACC_OUT, FLAGS_OUT;
  logic MEM_WE_OUT, MEM_RE_OUT, EA_RE_OUT, EA_WE_OUT, IRQ_TAKEN_OUT, acc_r, re_seen, we_seen;
  logic [3:0] SP_OUT;
  irq_src_t IRQ_SRC_OUT;
  int mismatches = 0, n_compared = 0, n_taken = 0;
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  always @(posedge CLK_SYS_IN) begin
    acc_r <= CMD_VALID_IN & CMD_READY_OUT;
    if (IRQ_TAKEN_OUT === 1'b1) n_taken <= n_taken + 1;
  end
  core_prog_model core_prog_model_i (.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN),
    .CMD_VALID_IN(CMD_VALID_IN), .CMD_OP_IN(CMD_OP_IN), .CMD_DATA_IN(CMD_DATA_IN),
    .CMD_ADDR_IN(CMD_ADDR_IN), .CMD_LEN_IN(CMD_LEN_IN), .CMD_READY_OUT(CMD_READY_OUT),
    .MAP_WR_IN(MAP_WR_IN), .MAP_RD_IN(MAP_RD_IN), .MAP_ADDR_IN(MAP_ADDR_IN),
    .MAP_WDATA_IN(MAP_WDATA_IN), .MAP_RDATA_OUT(MAP_RDATA_OUT), .MEM_RDATA_IN(MEM_RDATA_IN),
    .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_WE_OUT(MEM_WE_OUT),
    .MEM_RE_OUT(MEM_RE_OUT), .EA_OUT(EA_OUT), .EA_RE_OUT(EA_RE_OUT), .EA_WE_OUT(EA_WE_OUT),
    .FETCH_ADDR_OUT(FETCH_ADDR_OUT), .ACC_OUT(ACC_OUT), .FLAGS_OUT(FLAGS_OUT), .SP_OUT(SP_OUT),
    .EE_READY_IN(EE_READY_IN), .IRQ_EDGE_IN(IRQ_EDGE_IN), .IRQ_TMR0_IN(IRQ_TMR0_IN),
    .IRQ_TMR1_IN(IRQ_TMR1_IN), .IRQ_TAKEN_OUT(IRQ_TAKEN_OUT), .IRQ_SRC_OUT(IRQ_SRC_OUT));
  stack_ram_model stack_ram_model_i (.clk_in(CLK_SYS_IN), .addr_in(MEM_ADDR_OUT),
    .wdata_in(MEM_WDATA_OUT), .we_in(MEM_WE_OUT), .re_in(MEM_RE_OUT), .rdata_out(MEM_RDATA_IN));
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task timed_out;
    $display("wrong value handshake expected 1 seen timeout");
    mismatches++;
    end_of_test;
  endtask
  // request held until taken, then one idle cycle before the next
  task cmd(input op_t op, input logic [7:0] d, input logic [11:0] a, input logic [1:0] n);
    int k;
    CMD_OP_IN = op;
    CMD_DATA_IN = d;
    CMD_ADDR_IN = a;
    CMD_LEN_IN = n;
    CMD_VALID_IN = 1'b1;
    k = 0;
    do begin
      @(negedge CLK_SYS_IN);
      k++;
    end while (acc_r !== 1'b1 && k < 60);
    if (acc_r !== 1'b1) timed_out;
    CMD_VALID_IN = 1'b0;
    ea_seen = EA_OUT;
    re_seen = EA_RE_OUT;
    we_seen = EA_WE_OUT;
    @(negedge CLK_SYS_IN);
  endtask
  task idle;
    int k;
    k = 0;
    while (CMD_READY_OUT !== 1'b1 && k < 60) begin
      @(negedge CLK_SYS_IN);
      k++;
    end
    if (CMD_READY_OUT !== 1'b1) timed_out;
    @(negedge CLK_SYS_IN);
  endtask
  task wait_take;
    int k;
    k = 0;
    while (IRQ_TAKEN_OUT !== 1'b1 && k < 30) begin
      @(negedge CLK_SYS_IN);
      k++;
    end
    if (IRQ_TAKEN_OUT !== 1'b1) timed_out;
  endtask
  task map_wr(input logic [7:0] a, input logic [7:0] d);
    MAP_ADDR_IN = a;
    MAP_WDATA_IN = d;
    MAP_WR_IN = 1'b1;
    @(negedge CLK_SYS_IN);
    MAP_WR_IN = 1'b0;
    @(negedge CLK_SYS_IN);
  endtask
  task map_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    MAP_ADDR_IN = a;
    MAP_RD_IN = 1'b1;
    @(negedge CLK_SYS_IN);
    MAP_RD_IN = 1'b0;
    @(negedge CLK_SYS_IN);
    `CHECK(nm, e, MAP_RDATA_OUT)
  endtask
  initial begin
    repeat (3) @(negedge CLK_SYS_IN);
    SYS_RST_IN = 1'b0;
    `CHECK("sp", 4'hF, SP_OUT)
    `CHECK("fetch", 12'h0800, FETCH_ADDR_OUT)
    `CHECK("mask", 1'b0, FLAGS_OUT[4])
    map_rd(8'hEE, 8'h0F, "sp map");
    map_wr(8'hEF, 8'hFF);
    map_rd(8'hEF, 8'h9F, "flags map");
    map_wr(8'hEE, 8'h03);
    map_rd(8'hEE, 8'h03, "sp write");
    map_wr(8'hEE, 8'h0F);
    map_wr(8'h50, 8'hAA);
    map_rd(8'h50, 8'h00, "unmapped");
    $display("test registers done");
    map_wr(8'hEF, 8'h00);
    cmd(OP_CLR_A, 8'h00, 12'h000, 2'h1);
    cmd(OP_OR, 8'hF8, 12'h000, 2'h1);
    `CHECK("acc or", 8'hF8, ACC_OUT)
    `CHECK("zn or", 2'b01, {FLAGS_OUT[3], FLAGS_OUT[0]})
    cmd(OP_SC, 8'h00, 12'h000, 2'h1);
    cmd(OP_ADC, 8'h08, 12'h000, 2'h1);
    `CHECK("acc adc", 8'h01, ACC_OUT)
    `CHECK("zchn adc", 4'h6, FLAGS_OUT[3:0])
    cmd(OP_INVERT_CARRY, 8'h00, 12'h000, 2'h1);
    `CHECK("carry inv", 1'b0, FLAGS_OUT[2])
    cmd(OP_AND, 8'h00, 12'h000, 2'h1);
    `CHECK("zero and", 1'b1, FLAGS_OUT[3])
    cmd(OP_LOAD_CARRY_BIT, 8'h04, 12'h002, 2'h1);
    `CHECK("carry load", 1'b1, FLAGS_OUT[2])
    cmd(OP_RRC, 8'h00, 12'h000, 2'h1);
    `CHECK("rotate", 9'h080, {FLAGS_OUT[2], ACC_OUT})
    cmd(OP_LD_A, 8'h7F, 12'h000, 2'h1);
    cmd(OP_INC_A, 8'h00, 12'h000, 2'h1);
    `CHECK("inc zn", 10'h201, {ACC_OUT, FLAGS_OUT[3], FLAGS_OUT[0]})
    cmd(OP_XOR, 8'h80, 12'h000, 2'h1);
    `CHECK("xor zn", 10'h002, {ACC_OUT, FLAGS_OUT[3], FLAGS_OUT[0]})
    cmd(OP_DEC_A, 8'h00, 12'h000, 2'h1);
    cmd(OP_RC, 8'h00, 12'h000, 2'h1);
    cmd(OP_RLC, 8'h00, 12'h000, 2'h1);
    `CHECK("rotate left", 9'h1FE, {FLAGS_OUT[2], ACC_OUT})
    cmd(OP_ADD, 8'h02, 12'h000, 2'h1);
    `CHECK("add zn", 10'h002, {ACC_OUT, FLAGS_OUT[3], FLAGS_OUT[0]})
    $display("test arithmetic done");
    cmd(OP_LD_X, 8'h00, 12'h8F0, 2'h1);
    map_rd(8'hBE, 8'h00, "x high");
    map_rd(8'hBF, 8'hF0, "x low");
    cmd(OP_IDX_RD, 8'h20, 12'h000, 2'h1);
    `CHECK("ea prog", 13'h1910, {re_seen, ea_seen})
    cmd(OP_IDX_WR, 8'h20, 12'h000, 2'h1);
    `CHECK("code write", 1'b0, we_seen)
    cmd(OP_LD_X, 8'h00, 12'h0FF, 2'h1);
    cmd(OP_IDX_WR, 8'h02, 12'h000, 2'h1);
    `CHECK("ea data", 13'h1001, {we_seen, ea_seen})
    cmd(OP_LD_X, 8'h00, 12'hFFF, 2'h1);
    cmd(OP_INC_X, 8'h00, 12'h000, 2'h1);
    cmd(OP_IDX_RD, 8'h00, 12'h000, 2'h1);
    `CHECK("ea count", 12'h0800, ea_seen)
    cmd(OP_DEC_X, 8'h00, 12'h000, 2'h1);
    cmd(OP_IDX_RD, 8'h00, 12'h000, 2'h1);
    `CHECK("ea count down", 12'hFFF, ea_seen)
    map_wr(8'hBE, 8'h05);
    map_wr(8'hBF, 8'h34);
    map_rd(8'hBE, 8'h05, "x high wr");
    map_rd(8'hBF, 8'h34, "x low wr");
    $display("test pointer done");
    cmd(OP_JMP, 8'h00, 12'h123, 2'h3);
    cmd(OP_CALL_SUBROUTINE, 8'h00, 12'h456, 2'h3);
    idle;
    `CHECK("push lo", 8'h26, stack_ram_model_i.mem[15])
    `CHECK("push hi", 8'h01, stack_ram_model_i.mem[14])
    `CHECK("sp call", 4'hD, SP_OUT)
    `CHECK("call pc", 12'h0C56, FETCH_ADDR_OUT)
    cmd(OP_SUBROUTINE_RETURN, 8'h00, 12'h000, 2'h1);
    idle;
    `CHECK("return pc", 12'h0926, FETCH_ADDR_OUT)
    `CHECK("sp return", 4'hF, SP_OUT)
    $display("test subroutine done");
    for (int i = 0; i < 3; i++) begin
      map_wr(8'hEF, 8'h00);
      cmd(OP_JMP, 8'h00, 12'h200, 2'h3);
      {IRQ_EDGE_IN, IRQ_TMR0_IN, IRQ_TMR1_IN} = 3'b111 >> i;
      repeat (6) @(negedge CLK_SYS_IN);
      `CHECK("held", i, n_taken)
      cmd(OP_SET_G, 8'h00, 12'h000, 2'h1);
      wait_take;
      `CHECK("source", irq_src_t'(i), IRQ_SRC_OUT)
      {IRQ_EDGE_IN, IRQ_TMR0_IN, IRQ_TMR1_IN} = 3'b000;
      idle;
      `CHECK("vector", {1'b1, 11'h7F6 + 11'(2 * i)}, FETCH_ADDR_OUT)
      `CHECK("entry g sp", 5'h0D, {FLAGS_OUT[4], SP_OUT})
      cmd(OP_INTERRUPT_RETURN, 8'h00, 12'h000, 2'h1);
      idle;
      `CHECK("irq return", 13'h1A01, {FLAGS_OUT[4], FETCH_ADDR_OUT})
    end
    map_wr(8'hEF, 8'h00);
    cmd(OP_SOFTWARE_INTERRUPT, 8'h00, 12'h000, 2'h1);
    wait_take;
    `CHECK("soft source", IRQ_SOFT, IRQ_SRC_OUT)
    idle;
    `CHECK("soft vector", 13'h0FFC, {FLAGS_OUT[4], FETCH_ADDR_OUT})
    $display("test interrupts done");
    EE_READY_IN = 1'b0;
    repeat (2) @(negedge CLK_SYS_IN);
    `CHECK("ready flag", 1'b0, FLAGS_OUT[7])
    $display("test ready flag done");
    cmd(OP_SET_G, 8'h00, 12'h000, 2'h1);
    map_wr(8'hEE, 8'h03);
    `CHECK("mask set", 5'h13, {FLAGS_OUT[4], SP_OUT})
    SYS_RST_IN = 1'b1;
    repeat (3) @(negedge CLK_SYS_IN);
    SYS_RST_IN = 1'b0;
    `CHECK("reset again", 17'h0F800, {FLAGS_OUT[4], SP_OUT, FETCH_ADDR_OUT})
    $display("test reset done");
    end_of_test;
  end
endmodule
